// file: rtl/ppi_inhibit_reg.sv
// one inhibit register with per-bit write mask
// assumes the write strobe is a one-cycle pulse in the bus clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ppi_params.svh"

module ppi_inhibit_reg
  import ppi_pkg::*;
#(
  parameter int WIDTH = `PPI_REG_W,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter logic [WIDTH-1:0] WMASK = '1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] value_q
);

  // reserved bits are masked on the way in so they can never read as one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_q <= RESET_VAL & WMASK;
    end else if (wr_en) begin
      value_q <= wr_data & WMASK;
    end
  end

endmodule

`default_nettype wire

// file: rtl/ppi_params.svh
// constants for the pad pull inhibit register bank
// assumes inclusion by the package and the modules that decode the bank
`ifndef PPI_PARAMS_SVH
`define PPI_PARAMS_SVH

// register indices in word space, byte address is four times the index
`define PPI_CTL_IDX 16'h1C18
`define PPI_PPORT_IDX 16'h1C19
`define PPI_REG_W 16
`define PPI_BUS_W 32

// control pin register field positions
`define PPI_IRQ1_BIT 14
`define PPI_IRQ0_BIT 13
`define PPI_RST_BIT 12
`define PPI_EMU_BIT 11
`define PPI_TDI_BIT 10
`define PPI_TMS_BIT 9
`define PPI_TCK_BIT 8
`define PPI_ADDR_LSB 0
`define PPI_ADDR_MSB 5

// parallel port register field span
`define PPI_PPORT_LSB 2
`define PPI_PPORT_MSB 15

// writable bits and reset values
`define PPI_CTL_WMASK 16'h7F3F
`define PPI_CTL_RESET 16'h6000
`define PPI_PPORT_WMASK 16'hFFFC
`define PPI_PPORT_RESET 16'hFF00

// bus encodings
`define PPI_HTRANS_NONSEQ_BIT 1
`define PPI_HRESP_OKAY 1'h0

`endif

// file: rtl/ppi_pkg.sv
// types shared by the pad pull inhibit register bank
// assumes the params header is on the include path
`include "ppi_params.svh"

package ppi_pkg;

  // data phase tracking for the bus slave
  typedef enum logic [1:0] {
    PPI_PH_IDLE = 2'b00,
    PPI_PH_WRITE = 2'b01,
    PPI_PH_READ = 2'b10
  } ppi_phase_type;

  // which register an address hits
  typedef enum logic [1:0] {
    PPI_SEL_NONE = 2'b00,
    PPI_SEL_CTL = 2'b01,
    PPI_SEL_PPORT = 2'b10
  } ppi_sel_type;

  // pad controls of the control pin register, 1 turns the resistor off
  typedef struct packed {
    logic irq1_pullup_off;
    logic irq0_pullup_off;
    logic rst_pin_pullup_off;
    logic emulation_pins_pullup_off;
    logic test_data_in_pullup_off;
    logic test_mode_select_pullup_off;
    logic test_clock_pullup_off;
    logic [5:0] addr_pulldown_off;
  } ppi_ctl_pads_type;

endpackage

// file: rtl/ppi_pull_inhibit.sv
// pad pull inhibit register bank behind an ahb-lite slave port
// assumes one ahb-lite master, word transfers, and pads reading the control outputs
//
// Function
// - control register bit 14 set to 1 turns off interrupt 1 pullup
// - control register bit 13 set to 1 turns off interrupt 0 pullup
// - control register bit 12 set to 1 turns off reset pin pullup
// - control register bit 11 turns off both emulation pin pullups together
// - control register bit 10 set to 1 turns off test data in pullup
// - control register bit 9 set to 1 turns off test mode select pullup
// - control register bit 8 set to 1 turns off test clock pullup
// - control register bits 5 to 0 turn off address 20 to 15 pulldowns
// - parallel port register at index 1C19h, bits 15 to 2 per pin, upper byte resets high
// - control register bit 15 and bits 7 to 6 are reserved and read zero
// - control register sits at index 1C18h in the register space
`timescale 1ns/1ps
`default_nettype none
`include "ppi_params.svh"

module ppi_pull_inhibit
  import ppi_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output ppi_ctl_pads_type ctl_pads,
  output logic [`PPI_PPORT_MSB:`PPI_PPORT_LSB] pport_pulldown_off
);

  // control and parallel port register index
  // address decode, shared by the address phase and the write forwarding
  function automatic ppi_sel_type decode_addr(input logic [31:0] addr);
    logic [31:0] ctl_addr;
    logic [31:0] pport_addr;
    ctl_addr = {14'h0000, `PPI_CTL_IDX, 2'b00};
    pport_addr = {14'h0000, `PPI_PPORT_IDX, 2'b00};
    if (addr == ctl_addr) begin
      decode_addr = PPI_SEL_CTL;
    end else if (addr == pport_addr) begin
      decode_addr = PPI_SEL_PPORT;
    end else begin
      decode_addr = PPI_SEL_NONE;
    end
  endfunction

  ppi_phase_type phase_q;
  ppi_sel_type sel_q;
  ppi_sel_type addr_sel;
  logic addr_valid;
  logic wr_ctl;
  logic wr_pport;
  logic [`PPI_REG_W-1:0] ctl_val;
  logic [`PPI_REG_W-1:0] pport_val;
  logic [`PPI_REG_W-1:0] ctl_view;
  logic [`PPI_REG_W-1:0] pport_view;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic hreadyout_q;
  logic hresp_q;

  // hsize is not checked: every access is treated as a whole word
  assign addr_valid = hsel && htrans[`PPI_HTRANS_NONSEQ_BIT] && hready;
  assign addr_sel = decode_addr(haddr);

  // data phase bookkeeping, one transfer in flight at most
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= PPI_PH_IDLE;
      sel_q <= PPI_SEL_NONE;
    end else if (addr_valid) begin
      phase_q <= hwrite ? PPI_PH_WRITE : PPI_PH_READ;
      sel_q <= addr_sel;
    end else if (hready) begin
      phase_q <= PPI_PH_IDLE;
      sel_q <= PPI_SEL_NONE;
    end
  end

  // write strobes land at the end of the data phase, hwdata is valid there
  assign wr_ctl = (phase_q == PPI_PH_WRITE) && (sel_q == PPI_SEL_CTL);
  assign wr_pport = (phase_q == PPI_PH_WRITE) && (sel_q == PPI_SEL_PPORT);

  // reserved bits masked
  // control pin register, reserved bits hard zero through the mask
  ppi_inhibit_reg #(
    .WIDTH(`PPI_REG_W),
    .RESET_VAL(`PPI_CTL_RESET),
    .WMASK(`PPI_CTL_WMASK)
  ) u_ctl_reg (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_ctl),
    .wr_data(hwdata[`PPI_REG_W-1:0]),
    .value_q(ctl_val)
  );

  // parallel port register
  // parallel port register, upper byte comes out of reset high
  ppi_inhibit_reg #(
    .WIDTH(`PPI_REG_W),
    .RESET_VAL(`PPI_PPORT_RESET),
    .WMASK(`PPI_PPORT_WMASK)
  ) u_pport_reg (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pport),
    .wr_data(hwdata[`PPI_REG_W-1:0]),
    .value_q(pport_val)
  );

  // forward a write still in its data phase so a back-to-back read sees it
  always_comb begin
    ctl_view = ctl_val;
    pport_view = pport_val;
    if (wr_ctl) begin
      ctl_view = hwdata[`PPI_REG_W-1:0] & `PPI_CTL_WMASK;
    end
    if (wr_pport) begin
      pport_view = hwdata[`PPI_REG_W-1:0] & `PPI_PPORT_WMASK;
    end
  end

  // reserved bits read zero
  // read mux, unmapped addresses read as zero
  always_comb begin
    hrdata_d = hrdata_q;
    if (addr_valid && !hwrite) begin
      case (addr_sel)
        PPI_SEL_CTL: begin
          hrdata_d = {16'h0000, ctl_view};
        end
        PPI_SEL_PPORT: begin
          hrdata_d = {16'h0000, pport_view};
        end
        default: begin
          hrdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data registered in the address phase, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  // zero wait states and always okay; the flops keep outputs glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= `PPI_HRESP_OKAY;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= `PPI_HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // pullup bit map
  // pads follow the stored bits with no extra logic between
  assign ctl_pads.irq1_pullup_off = ctl_val[`PPI_IRQ1_BIT];
  assign ctl_pads.irq0_pullup_off = ctl_val[`PPI_IRQ0_BIT];
  assign ctl_pads.rst_pin_pullup_off = ctl_val[`PPI_RST_BIT];
  assign ctl_pads.emulation_pins_pullup_off = ctl_val[`PPI_EMU_BIT];
  assign ctl_pads.test_data_in_pullup_off = ctl_val[`PPI_TDI_BIT];
  assign ctl_pads.test_mode_select_pullup_off = ctl_val[`PPI_TMS_BIT];
  assign ctl_pads.test_clock_pullup_off = ctl_val[`PPI_TCK_BIT];

  // address pulldown map
  // address pulldowns, bit 0 is address 15 and bit 5 is address 20
  assign ctl_pads.addr_pulldown_off = ctl_val[`PPI_ADDR_MSB:`PPI_ADDR_LSB];

  // per pin pulldown
  // one pad control per parallel port pin, same index as the register bit
  generate
    for (genvar i = `PPI_PPORT_LSB; i <= `PPI_PPORT_MSB; i++) begin : g_pport
      assign pport_pulldown_off[i] = pport_val[i];
    end
  endgenerate

  // checks, tied to the bus write or read that causes the effect, to reset, to pad stability or to the bus response

  chk_irq1_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.irq1_pullup_off == $past(hwdata[`PPI_IRQ1_BIT]))
    else $error("interrupt 1 pullup control does not follow write");

  chk_irq0_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.irq0_pullup_off == $past(hwdata[`PPI_IRQ0_BIT]))
    else $error("interrupt 0 pullup control does not follow write");

  chk_rst_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.rst_pin_pullup_off == $past(hwdata[`PPI_RST_BIT]))
    else $error("reset pin pullup control does not follow write");

  chk_emu_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.emulation_pins_pullup_off == $past(hwdata[`PPI_EMU_BIT]))
    else $error("emulation pullup control does not follow write");

  chk_jtag_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.test_data_in_pullup_off == $past(hwdata[`PPI_TDI_BIT]))
    else $error("test data in pullup control does not follow write");

  chk_tms_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.test_mode_select_pullup_off == $past(hwdata[`PPI_TMS_BIT]))
    else $error("test mode select pullup control does not follow write");

  chk_tck_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.test_clock_pullup_off == $past(hwdata[`PPI_TCK_BIT]))
    else $error("test clock pullup control does not follow write");

  chk_addr_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> ctl_pads.addr_pulldown_off == $past(hwdata[`PPI_ADDR_MSB:`PPI_ADDR_LSB]))
    else $error("address pulldown controls do not follow write");

  chk_pport_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_valid && hwrite && haddr == {14'h0000, `PPI_PPORT_IDX, 2'b00})
    ##1 hready |=> pport_pulldown_off == $past(hwdata[`PPI_PPORT_MSB:`PPI_PPORT_LSB]))
    else $error("parallel port pulldown controls do not follow write");

  chk_ctl_reserved: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_valid && !hwrite && addr_sel == PPI_SEL_CTL)
    |=> (hrdata & ~{16'h0000, `PPI_CTL_WMASK}) == 32'h0000_0000)
    else $error("control register reserved bits read nonzero");

  chk_ctl_readback: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_valid && !hwrite && haddr == {14'h0000, `PPI_CTL_IDX, 2'b00} && !wr_ctl)
    |=> hrdata == {16'h0000, $past(ctl_val)})
    else $error("control register read does not return stored value");

  chk_pads_stable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_ctl || wr_pport) |=> $stable(ctl_pads) && $stable(pport_pulldown_off))
    else $error("pad controls changed without a register write");

  chk_ctl_reset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> ctl_val == (`PPI_CTL_RESET & `PPI_CTL_WMASK))
    else $error("control register not at its reset value after reset");

  chk_pport_reset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> pport_val == (`PPI_PPORT_RESET & `PPI_PPORT_WMASK))
    else $error("parallel port register not at its reset value after reset");

  chk_ctl_stored_rsvd: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl
    |=> (ctl_val & ~`PPI_CTL_WMASK) == 16'h0000)
    else $error("control register stored a reserved bit");

  chk_pport_reserved: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_valid && !hwrite && addr_sel == PPI_SEL_PPORT)
    |=> (hrdata & ~{16'h0000, `PPI_PPORT_WMASK}) == 32'h0000_0000)
    else $error("parallel port register reserved bits read nonzero");

  chk_pport_readback: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_valid && !hwrite && addr_sel == PPI_SEL_PPORT && !wr_pport)
    |=> hrdata == {16'h0000, $past(pport_val)})
    else $error("parallel port register read does not return stored value");

  chk_unmapped_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_valid && !hwrite && addr_sel == PPI_SEL_NONE)
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped address read returns nonzero data");

  chk_unmapped_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_valid && hwrite && addr_sel == PPI_SEL_NONE)
    |=> ##1 $stable(ctl_val) && $stable(pport_val))
    else $error("unmapped address write changed a register");

  chk_bus_okay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout && hresp == `PPI_HRESP_OKAY)
    else $error("bus slave stalled or answered with an error");

endmodule

`default_nettype wire

// file: test/ppi_pull_inhibit_tb.sv
// self-checking bench for the pad pull inhibit register bank
// assumes a single ahb-lite slave whose hreadyout is the bus hready
`timescale 1ns/1ps
`default_nettype none
`include "ppi_params.svh"

module ppi_pull_inhibit_tb
  import ppi_pkg::*;
();
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  ppi_ctl_pads_type ctl_pads;
  logic [15:2] pport_pulldown_off;
  int n_mismatch;
  int total_checks;
  localparam logic [31:0] ctl_addr = 32'(`PPI_CTL_IDX) << 2;
  localparam logic [31:0] pport_addr = 32'(`PPI_PPORT_IDX) << 2;

  // one slave on the bus, so its ready closes every phase
  assign hready = hreadyout;

  ppi_pull_inhibit dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ctl_pads(ctl_pads), .pport_pulldown_off(pport_pulldown_off)
  );

  // free running 200 mhz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for the edge that samples ready high
  task wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 16) begin
        n_mismatch++;
        $display("ERROR at %0t: got %h expected %h", $time, hready, 1'b1);
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  task addr_phase(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
  endtask

  task bus_write(input logic [31:0] a, input logic [31:0] d);
    addr_phase(a, 1'b1);
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask

  task bus_read(input logic [31:0] a, output logic [31:0] d);
    addr_phase(a, 1'b1 ^ 1'b1);
    wait_ready();
    htrans <= 2'b00;
    wait_ready();
    d = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  // write data phase overlaps the read address phase of the same register
  task wr_rd(input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    addr_phase(a, 1'b1);
    wait_ready();
    hwdata <= d;
    addr_phase(a, 1'b0);
    wait_ready();
    htrans <= 2'b00;
    wait_ready();
    r = hrdata;
  endtask

  // reads both registers, then the pads, which have been quiet since the last write
  task check_regs(input logic [15:0] c, input logic [15:0] p);
    logic [31:0] r;
    bus_read(ctl_addr, r);
    chk(r, {16'h0000, c});
    bus_read(pport_addr, r);
    chk(r, {16'h0000, p});
    chk({19'h0, ctl_pads}, {19'h0, c[14:8], c[5:0]});
    chk({18'h0, pport_pulldown_off}, {18'h0, p[15:2]});
  endtask

  task do_reset();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task test_reset();
    check_regs(16'h6000, 16'hff00);
    $display("test_reset done");
  endtask

  // a write with the slave not selected must leave both registers alone
  task test_deselect();
    hsel <= 1'b0;
    haddr <= ctl_addr;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= 32'h0000_ffff;
    wait_ready();
    check_regs(16'h6000, 16'hff00);
    $display("test_deselect done");
  endtask

  // walking one shows each field lands on its own pad and reserved bits drop
  task test_ctl_bits();
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 16'h0001 << i;
      bus_write(ctl_addr, {16'hffff, v});
      check_regs(v & 16'h7f3f, 16'hff00);
    end
    bus_write(ctl_addr, 32'hffff_ffff);
    check_regs(16'h7f3f, 16'hff00);
    bus_write(ctl_addr, 32'h0000_0000);
    check_regs(16'h0000, 16'hff00);
    $display("test_ctl_bits done");
  endtask

  task test_pport_bits();
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 16'h0001 << i;
      bus_write(pport_addr, {16'hffff, v});
      check_regs(16'h0000, v & 16'hfffc);
    end
    bus_write(pport_addr, 32'hffff_ffff);
    check_regs(16'h0000, 16'hfffc);
    $display("test_pport_bits done");
  endtask

  // neighbours of the two registers must neither answer nor alias
  task test_unmapped();
    logic [31:0] r;
    bus_write(ctl_addr, 32'h0000_5a15);
    bus_write(pport_addr, 32'h0000_3c3c);
    bus_write(32'h0000_705c, 32'hffff_ffff);
    bus_write(32'h0000_7068, 32'hffff_ffff);
    bus_read(32'h0000_705c, r);
    chk(r, 32'h0000_0000);
    bus_read(32'h0000_7068, r);
    chk(r, 32'h0000_0000);
    check_regs(16'h5a15, 16'h3c3c);
    $display("test_unmapped done");
  endtask

  task test_b2b();
    logic [31:0] r;
    wr_rd(ctl_addr, 32'h0000_2aca, r);
    chk(r, 32'h0000_2a0a);
    wr_rd(pport_addr, 32'h0000_00ff, r);
    chk(r, 32'h0000_00fc);
    $display("test_b2b done");
  endtask

  // a second reset in mid-run brings back the reset values
  task test_midrun_reset();
    bus_write(ctl_addr, 32'h0000_1f3f);
    bus_write(pport_addr, 32'h0000_00fc);
    do_reset();
    check_regs(16'h6000, 16'hff00);
    $display("test_midrun_reset done");
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    n_mismatch = 0;
    total_checks = 0;
    do_reset();
    test_reset();
    test_deselect();
    test_ctl_bits();
    test_pport_bits();
    test_unmapped();
    test_b2b();
    test_midrun_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
